// ### rtl/aprst_defines.svh
// register offsets, bit positions and timing constants of the peripheral soft reset block
`ifndef APRST_DEFINES_SVH
`define APRST_DEFINES_SVH

`define APRST_OFS_CTRL0 12'h108
`define APRST_OFS_CTRL1 12'h10C
`define APRST_ADDR_W 12
`define APRST_RESET_VAL 32'h00000000
// implemented bits of each control register
`define APRST_MASK0 32'h0B00CF33
`define APRST_MASK1 32'h01430313
// bit positions, first register
`define APRST_B0_SMARTCARD1 27
`define APRST_B0_AUDIO_SERIAL 25
`define APRST_B0_SMARTCARD0 24
`define APRST_B0_EXT_IRQ 15
`define APRST_B0_ALT_FUNC 14
`define APRST_B0_UART_B 11
`define APRST_B0_UART_A 10
`define APRST_B0_USART_B 9
`define APRST_B0_USART_A 8
`define APRST_B0_SPI_B 5
`define APRST_B0_SPI_A 4
`define APRST_B0_TWI_B 1
`define APRST_B0_TWI_A 0
// bit positions, second register
`define APRST_B1_CONVERTER 24
`define APRST_B1_COMPARATOR 22
`define APRST_B1_BTIM_B 17
`define APRST_B1_BTIM_A 16
`define APRST_B1_GPTIM_B 9
`define APRST_B1_GPTIM_A 8
`define APRST_B1_WATCHDOG 4
`define APRST_B1_MTIM_B 1
`define APRST_B1_MTIM_A 0
// reset pulse width in clock cycles
`define APRST_PULSE_CYC 2'd1

`endif

// ### rtl/aprst_pkg.sv
// types shared by the peripheral soft reset block
package aprst_pkg;
   typedef logic [31:0] aprst_word_type;
endpackage : aprst_pkg

// ### rtl/aprst_top.sv
// apb peripheral soft reset generator with two self-clearing control registers
`timescale 1ns/10ps
`default_nettype none
`include "aprst_defines.svh"

// Function
// - implemented bits set by software writing one, cleared by hardware afterwards
// - both registers read zero after reset, at offsets 0x108 and 0x10C
// - first register bits 27 and 24 reset smart card interfaces 1 and 0
// - first register bit 25 resets the audio serial interface
// - first register bit 15 resets the external interrupt controller
// - first register bit 14 resets the alternate function unit
// - first register bits 11,10 reset uarts; bits 9,8 reset usarts
// - first register bits 5 and 4 reset serial peripheral interfaces 1 and 0
// - first register bits 1 and 0 reset two-wire controllers 1 and 0
// - second register bit 24 resets the converter control logic
// - second register bit 22 resets the comparator controller
// - second register bits 17 and 16 reset basic timers 1 and 0
// - second register bits 9 and 8 reset general purpose timers 1 and 0
// - second register bit 4 resets the watchdog block
// - second register bits 1 and 0 reset motor control timers 1 and 0
// - system or power-on reset also resets every attached peripheral
module aprst_top
   import aprst_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic smartcard1_reset,
   output logic smartcard0_reset,
   output logic audio_serial_reset,
   output logic ext_irq_ctrl_reset,
   output logic alt_func_io_reset,
   output logic uart_b_reset,
   output logic uart_a_reset,
   output logic usart_b_reset,
   output logic usart_a_reset,
   output logic serial_periph_b_reset,
   output logic serial_periph_a_reset,
   output logic two_wire_b_reset,
   output logic two_wire_a_reset,
   output logic converter_reset,
   output logic comparator_reset,
   output logic basic_timer_b_reset,
   output logic basic_timer_a_reset,
   output logic gp_timer_b_reset,
   output logic gp_timer_a_reset,
   output logic watchdog_block_reset,
   output logic motor_timer_b_reset,
   output logic motor_timer_a_reset
);
   import aprst_pkg::*;

   logic rst_meta_q;
   logic rst_sync_q;
   logic rst_n;
   aprst_word_type ctrl0_q;
   aprst_word_type ctrl0_d;
   aprst_word_type ctrl1_q;
   aprst_word_type ctrl1_d;
   aprst_word_type pulse0_q;
   aprst_word_type pulse1_q;
   aprst_word_type prdata_d;
   wire access_w;
   wire hit0_w;
   wire hit1_w;
   wire wr0_w;
   wire wr1_w;
   wire [`APRST_ADDR_W-1:0] offset_w;

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_n = rst_sync_q;

   // apb decode; zero wait state, unmapped addresses answer an error
   assign offset_w = paddr[`APRST_ADDR_W-1:0];
   assign access_w = psel & penable;
   assign hit0_w = (offset_w == `APRST_OFS_CTRL0) && (paddr[31:`APRST_ADDR_W] == '0);
   assign hit1_w = (offset_w == `APRST_OFS_CTRL1) && (paddr[31:`APRST_ADDR_W] == '0);
   assign wr0_w = access_w & pwrite & hit0_w;
   assign wr1_w = access_w & pwrite & hit1_w;
   assign pready = 1'b1;
   assign pslverr = access_w & ~(hit0_w | hit1_w);

   // zero writes ignored
   // a bit lives one cycle: masked written ones are loaded in place of the stored ones, which drop next edge
   assign ctrl0_d = wr0_w ? (pwdata & `APRST_MASK0) : `APRST_RESET_VAL;
   assign ctrl1_d = wr1_w ? (pwdata & `APRST_MASK1) : `APRST_RESET_VAL;

   // read mux shows bits still pending; reads otherwise return zero
   assign prdata_d = hit0_w ? ctrl0_q : (hit1_w ? ctrl1_q : `APRST_RESET_VAL);

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl0_q <= `APRST_RESET_VAL;
         ctrl1_q <= `APRST_RESET_VAL;
      end
      else
      begin
         ctrl0_q <= ctrl0_d;
         ctrl1_q <= ctrl1_d;
      end
   end

   // registered one cycle pulse
   // pulse follows the control bit so the peripheral sees a clean flop output
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pulse0_q <= `APRST_RESET_VAL;
         pulse1_q <= `APRST_RESET_VAL;
         prdata <= `APRST_RESET_VAL;
      end
      else
      begin
         pulse0_q <= ctrl0_q;
         pulse1_q <= ctrl1_q;
         prdata <= prdata_d;
      end
   end

   // hardware reset reaches all peripherals
   // every line is one pulse bit merged with the internal reset
   // smart card lines listed first, then the other peripheral lines; all assert in the same cycle
   aprst_line smartcard1_line_inst
   (
      .req_bit(pulse0_q[`APRST_B0_SMARTCARD1]),
      .rst_n(rst_n),
      .line(smartcard1_reset)
   );
   aprst_line smartcard0_line_inst
   (
      .req_bit(pulse0_q[`APRST_B0_SMARTCARD0]),
      .rst_n(rst_n),
      .line(smartcard0_reset)
   );
   aprst_line audio_serial_line_inst
   (
      .req_bit(pulse0_q[`APRST_B0_AUDIO_SERIAL]),
      .rst_n(rst_n),
      .line(audio_serial_reset)
   );
   aprst_line ext_irq_line_inst
   (
      .req_bit(pulse0_q[`APRST_B0_EXT_IRQ]),
      .rst_n(rst_n),
      .line(ext_irq_ctrl_reset)
   );
   aprst_line alt_func_line_inst
   (
      .req_bit(pulse0_q[`APRST_B0_ALT_FUNC]),
      .rst_n(rst_n),
      .line(alt_func_io_reset)
   );
   aprst_line uart_b_line_inst
   (
      .req_bit(pulse0_q[`APRST_B0_UART_B]),
      .rst_n(rst_n),
      .line(uart_b_reset)
   );
   aprst_line uart_a_line_inst
   (
      .req_bit(pulse0_q[`APRST_B0_UART_A]),
      .rst_n(rst_n),
      .line(uart_a_reset)
   );
   aprst_line usart_b_line_inst
   (
      .req_bit(pulse0_q[`APRST_B0_USART_B]),
      .rst_n(rst_n),
      .line(usart_b_reset)
   );
   aprst_line usart_a_line_inst
   (
      .req_bit(pulse0_q[`APRST_B0_USART_A]),
      .rst_n(rst_n),
      .line(usart_a_reset)
   );
   aprst_line serial_periph_b_line_inst
   (
      .req_bit(pulse0_q[`APRST_B0_SPI_B]),
      .rst_n(rst_n),
      .line(serial_periph_b_reset)
   );
   aprst_line serial_periph_a_line_inst
   (
      .req_bit(pulse0_q[`APRST_B0_SPI_A]),
      .rst_n(rst_n),
      .line(serial_periph_a_reset)
   );
   aprst_line two_wire_b_line_inst
   (
      .req_bit(pulse0_q[`APRST_B0_TWI_B]),
      .rst_n(rst_n),
      .line(two_wire_b_reset)
   );
   aprst_line two_wire_a_line_inst
   (
      .req_bit(pulse0_q[`APRST_B0_TWI_A]),
      .rst_n(rst_n),
      .line(two_wire_a_reset)
   );
   aprst_line converter_line_inst
   (
      .req_bit(pulse1_q[`APRST_B1_CONVERTER]),
      .rst_n(rst_n),
      .line(converter_reset)
   );
   aprst_line comparator_line_inst
   (
      .req_bit(pulse1_q[`APRST_B1_COMPARATOR]),
      .rst_n(rst_n),
      .line(comparator_reset)
   );
   aprst_line basic_timer_b_line_inst
   (
      .req_bit(pulse1_q[`APRST_B1_BTIM_B]),
      .rst_n(rst_n),
      .line(basic_timer_b_reset)
   );
   aprst_line basic_timer_a_line_inst
   (
      .req_bit(pulse1_q[`APRST_B1_BTIM_A]),
      .rst_n(rst_n),
      .line(basic_timer_a_reset)
   );
   aprst_line gp_timer_b_line_inst
   (
      .req_bit(pulse1_q[`APRST_B1_GPTIM_B]),
      .rst_n(rst_n),
      .line(gp_timer_b_reset)
   );
   aprst_line gp_timer_a_line_inst
   (
      .req_bit(pulse1_q[`APRST_B1_GPTIM_A]),
      .rst_n(rst_n),
      .line(gp_timer_a_reset)
   );
   aprst_line watchdog_line_inst
   (
      .req_bit(pulse1_q[`APRST_B1_WATCHDOG]),
      .rst_n(rst_n),
      .line(watchdog_block_reset)
   );
   aprst_line motor_timer_b_line_inst
   (
      .req_bit(pulse1_q[`APRST_B1_MTIM_B]),
      .rst_n(rst_n),
      .line(motor_timer_b_reset)
   );
   aprst_line motor_timer_a_line_inst
   (
      .req_bit(pulse1_q[`APRST_B1_MTIM_A]),
      .rst_n(rst_n),
      .line(motor_timer_a_reset)
   );

endmodule : aprst_top

// one peripheral reset line: software pulse or internal reset
module aprst_line
(
   input wire logic req_bit,
   input wire logic rst_n,
   output logic line
);
   import aprst_pkg::*;

   // held high through system reset so every peripheral starts clean
   assign line = req_bit | ~rst_n;
endmodule : aprst_line
`default_nettype wire

// ### tb/aprst_periph.sv
// peripheral side model collecting the reset pulses it receives
`timescale 1ns/10ps
`default_nettype none
module aprst_periph (
   input wire logic clock,
   input wire logic clr,
   input wire logic [21:0] lines,
   output logic [21:0] seen_q
);
   // sticky, so a one-cycle pulse is not missed unless clr is high on that edge
   always_ff @(posedge clock)
   begin
      seen_q <= clr ? 22'h000000 : seen_q | lines;
   end
endmodule : aprst_periph
`default_nettype wire

// ### tb/aprst_properties.sv
// port-level checks for the peripheral soft reset block
`timescale 1ns/10ps
`default_nettype none
module aprst_props (
   input wire logic clock,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic usart_a_reset,
   input wire logic two_wire_a_reset,
   input wire logic watchdog_block_reset,
   input wire logic converter_reset
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   // access decode per register
   wire logic acc = psel && penable;
   wire logic hit0 = paddr == 32'h00000108;
   wire logic hit1 = paddr == 32'h0000010C;
   wire logic w0 = acc && pwrite && hit0;
   wire logic w1 = acc && pwrite && hit1;
   usart_pulse_a: assert property (w0 && pwdata[8] |=> ##1 usart_a_reset)
      else $error("usart reset pulse missing");
   pulse_width_a: assert property ($rose(usart_a_reset) |=> !usart_a_reset)
      else $error("reset pulse too long");
   wd_cause_a: assert property ($rose(watchdog_block_reset) |-> $past(w1 && pwdata[4], 2))
      else $error("stray watchdog reset");
   twi_cause_a: assert property ($rose(two_wire_a_reset) |-> $past(w0 && pwdata[0], 2))
      else $error("stray two-wire reset");
   zero_ignored_a: assert property (w1 && !pwdata[24] |=> ##1 !converter_reset)
      else $error("reset without a one written");
   sys_reset_a: assert property ($rose(nrst) |-> converter_reset)
      else $error("system reset not passed on");
   err_unmapped_a: assert property (acc && !hit0 && !hit1 |-> pslverr)
      else $error("unmapped access not refused");
   err_mapped_a: assert property (acc && (hit0 || hit1) |-> pready && !pslverr)
      else $error("mapped access refused");
endmodule : aprst_props
bind aprst_top aprst_props aprst_props_inst (.*);
`default_nettype wire

// ### tb/aprst_top_bench.sv
// self-checking bench for the peripheral soft reset block
`timescale 1ns/10ps
`default_nettype none
`include "aprst_defines.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %0t %h %h", $time, a, e); end end
module aprst_top_bench;
   import aprst_pkg::*;
   logic clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, clr = 0, err;
   logic [31:0] paddr = '0, pwdata = '0;
   aprst_word_type prdata, rd;
   wire logic pready, pslverr;
   wire logic [21:0] rl, seen;
   int n_mismatch = 0, checked = 0;
   // both masks, first register in the low half
   localparam logic [63:0] MASK = {`APRST_MASK1, `APRST_MASK0};
   always #2 clock = ~clock;
   aprst_top aprst_top_inst (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .two_wire_a_reset(rl[0]), .two_wire_b_reset(rl[1]),
      .serial_periph_a_reset(rl[2]), .serial_periph_b_reset(rl[3]), .usart_a_reset(rl[4]),
      .usart_b_reset(rl[5]), .uart_a_reset(rl[6]), .uart_b_reset(rl[7]),
      .alt_func_io_reset(rl[8]), .ext_irq_ctrl_reset(rl[9]), .smartcard0_reset(rl[10]),
      .audio_serial_reset(rl[11]), .smartcard1_reset(rl[12]), .motor_timer_a_reset(rl[13]),
      .motor_timer_b_reset(rl[14]), .watchdog_block_reset(rl[15]), .gp_timer_a_reset(rl[16]),
      .gp_timer_b_reset(rl[17]), .basic_timer_a_reset(rl[18]), .basic_timer_b_reset(rl[19]),
      .comparator_reset(rl[20]), .converter_reset(rl[21]));
   aprst_periph aprst_periph_inst (.clock(clock), .clr(clr), .lines(rl), .seen_q(seen));
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge so a following call never reassigns psel in this step
      @(posedge clock);
   endtask : apb
   // output line expected for one bit position
   function automatic logic [21:0] exp_f(input int p);
      int r = 0;
      for (int i = 0; i < p; i++) r += MASK[i];
      return MASK[p] ? 22'h000001 << r : 22'h000000;
   endfunction : exp_f
   task automatic t_sys(input int n);
      nrst <= 1'b0;
      repeat (n) @(posedge clock);
      nrst <= 1'b1;
      repeat (4) @(posedge clock);
      `CHK(seen, 22'h3FFFFF)
      clr <= 1'b1;
      @(posedge clock);
      clr <= 1'b0;
   endtask : t_sys
   task automatic t_regs();
      apb(1'b0, 32'h00000108, '0);
      `CHK(rd, 32'h00000000)
      apb(1'b0, 32'h0000010C, '0);
      `CHK(rd, 32'h00000000)
      apb(1'b1, 32'h00000110, 32'hFFFFFFFF);
      `CHK(err, 1'b1)
   endtask : t_regs
   // every position, then a zero write straight after
   task automatic t_bits();
      logic [31:0] a;
      for (int p = 0; p < 64; p++)
      begin
         a = p < 32 ? 32'h00000108 : 32'h0000010C;
         apb(1'b1, a, 32'h00000001 << p[4:0]);
         apb(1'b1, a, 32'h00000000);
         apb(1'b0, a, 32'h00000000);
         `CHK(rd, 32'h00000000)
         `CHK(seen, exp_f(p))
         clr <= 1'b1;
         @(posedge clock);
         clr <= 1'b0;
      end
   endtask : t_bits
   task automatic conclude();
      if (n_mismatch == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude
   initial
   begin
      t_sys(20);
      t_regs();
      t_bits();
      t_sys(3);
      conclude();
   end
   // cut a hang short
   initial
   begin
      #40000;
      n_mismatch++;
      conclude();
   end
endmodule : aprst_top_bench
`default_nettype wire
